// *** hdl/seebfe_pkg.sv ***
// Package for the serial EEPROM bus front end: sizes, field positions,
// timing constants, state enum and a carrier struct.
// Assumes a 40 MHz core clock.
package seebfe_pkg;
    localparam int          ARRAY_DEPTH   = 512;
    localparam int          ADDR_W        = 9;
    localparam int          DATA_W        = 8;
    localparam int          PAGE_BYTES    = 16;
    localparam int          PAGE_OFS_W    = 4;
    localparam int          CORE_CLK_MHZ  = 40;
    localparam int          WRITE_TIME_US = 5000;
    localparam int          WRITE_CYCLES  =
        (WRITE_TIME_US * CORE_CLK_MHZ) - 1;
    localparam logic [3:0]  SELECT_CODE   = 4'ha;
    localparam int          SEL_HI_BIT    = 7;
    localparam int          SEL_LO_BIT    = 4;
    localparam int          STRAP_HI_BIT  = 3;
    localparam int          STRAP_LO_BIT  = 2;
    localparam int          ADDR_MSB_BIT  = 1;
    localparam int          RW_BIT        = 0;
    localparam logic [3:0]  BIT_ACK       = 4'h8;
    localparam logic [3:0]  BIT_LAST      = 4'h7;

    typedef enum logic [2:0] {
        SEEBFE_IDLE,
        SEEBFE_DEVSEL,
        SEEBFE_WORD,
        SEEBFE_WDATA,
        SEEBFE_RDATA,
        SEEBFE_IGNORE
    } seebfe_state_e;

    // One byte to program, handed from the link to the core domain
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } seebfe_wr_s;
endpackage : seebfe_pkg

// *** hdl/seebfe_mem.sv ***
// Array storage for the EEPROM front end.
// Assumes a single write port and registered read data, one clock.
`timescale 1ns/1ps
module seebfe_mem (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [8:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [8:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] store [0:seebfe_pkg::ARRAY_DEPTH-1];

    // Write and registered read; contents are nonvolatile in intent
    always_ff @(posedge clk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end
endmodule : seebfe_mem

// *** hdl/seebfe_top.sv ***
// Summary of operation
// [RL1] Array of 512 bytes, individually addressed
// [RL2] Page write up to 16, partial allowed
// [RL3] Self-timed programming done within 5 ms
// [RL4] Random and sequential reads supported
// [RL5] Protect input high blocks upper-half writes
// [RL6] Answer only when straps match address
// [RL7] Floating straps and protect read low
// [RL8] Data line only pulled low or released
// [RL9] Incoming bits captured on clock rise
// [RL10] Outgoing bits changed on clock fall
// [RL11] Controller keeps serial clock high idle
// [RL12] Nine-bit address: top bit in select
//
// Two-wire target front end of a 512 byte EEPROM.
// Assumes scl_in is the link clock (the controller's serial clock),
// sda is open drain with an external pull-up, and pins are resolved
// (pull-downs applied) before reaching the straps and protect input.
`timescale 1ns/1ps
module seebfe_top (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic chip_select_strap_low,
    input  wire logic chip_select_strap_high,
    input  wire logic write_protect,
    output logic      write_busy
);
    ////////////////////////////////////////////////////////////////////
    // Link domain: start/stop detection and bit engine on scl_in

    // Link flops have no reset pin to use: control flops power up at known values
    seebfe_pkg::seebfe_state_e state_reg = seebfe_pkg::SEEBFE_IDLE;
    logic [3:0] bit_cnt_reg   = 4'h0;
    logic [7:0] shift_reg;
    logic       rw_reg        = 1'b0;
    logic [8:0] addr_reg;
    logic       sel_ack_reg   = 1'b0;
    logic       ack_drive_reg = 1'b0;
    logic       tx_bit_reg    = 1'b1;
    logic       nack_seen_reg;
    logic       start_tgl_reg = 1'b0;
    logic       stop_tgl_reg  = 1'b0;
    logic       start_ack_reg = 1'b0;
    logic       wr_tgl_reg    = 1'b0;
    seebfe_pkg::seebfe_wr_s wr_hold_reg;
    logic [7:0] rd_byte_l;
    logic       busy_l1_reg   = 1'b0;
    logic       busy_l2_reg   = 1'b0;
    logic [2:0] pin_s1_reg    = 3'h0;
    logic [2:0] pin_s2_reg    = 3'h0;

    // Start and stop are data edges with clock high. The toggles are
    // sampled on the next clock rise, so no async reset is needed.
    always_ff @(negedge sda_in) begin
        if (scl_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    always_ff @(posedge sda_in) begin
        if (scl_in) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    logic       stop_ack_reg = 1'b0;
    wire        start_pend = start_tgl_reg ^ start_ack_reg;
    wire        stop_pend  = stop_tgl_reg ^ stop_ack_reg;
    wire  [7:0] rx_byte    = {shift_reg[6:0], sda_in};
    wire        strap_ok   =
        rx_byte[seebfe_pkg::SEL_HI_BIT:seebfe_pkg::SEL_LO_BIT] ==
            seebfe_pkg::SELECT_CODE &&
        rx_byte[seebfe_pkg::STRAP_HI_BIT] == pin_s2_reg[2] &&
        rx_byte[seebfe_pkg::STRAP_LO_BIT] == pin_s2_reg[1]; // RL6 RL7
    wire  [8:0] sel_addr   =
        {rx_byte[seebfe_pkg::ADDR_MSB_BIT], addr_reg[7:0]};     // RL12
    wire        upper_half = addr_reg[seebfe_pkg::ADDR_W-1];
    wire        wr_allow   = !(pin_s2_reg[0] && upper_half);    // RL5
    wire  [8:0] page_next  = {addr_reg[8:seebfe_pkg::PAGE_OFS_W],
                              addr_reg[3:0] + 4'h1};            // RL2

    // Receive side: all line sampling on the rising clock edge
    always_ff @(posedge scl_in) begin
        start_ack_reg <= start_tgl_reg;
        stop_ack_reg  <= stop_tgl_reg;
        shift_reg     <= rx_byte;                                // RL9
        if (start_pend) begin
            state_reg   <= seebfe_pkg::SEEBFE_DEVSEL;
            bit_cnt_reg <= 4'h1;
            sel_ack_reg <= 1'b0;
            shift_reg   <= {7'h00, sda_in};
        end else if (stop_pend) begin
            state_reg <= seebfe_pkg::SEEBFE_IDLE;
        end else if (bit_cnt_reg == seebfe_pkg::BIT_ACK) begin
            bit_cnt_reg   <= 4'h0;
            sel_ack_reg   <= 1'b0;
            nack_seen_reg <= sda_in;
            if (state_reg == seebfe_pkg::SEEBFE_RDATA && sda_in) begin
                state_reg <= seebfe_pkg::SEEBFE_IGNORE;
            end
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == seebfe_pkg::BIT_LAST) begin
                case (state_reg)
                    seebfe_pkg::SEEBFE_DEVSEL: begin
                        if (!strap_ok || busy_l2_reg) begin
                            state_reg <= seebfe_pkg::SEEBFE_IGNORE;
                        end else begin
                            rw_reg   <= rx_byte[seebfe_pkg::RW_BIT];
                            sel_ack_reg <= 1'b1;
                            addr_reg <= sel_addr;
                            state_reg <= rx_byte[seebfe_pkg::RW_BIT] ?
                                seebfe_pkg::SEEBFE_RDATA :
                                seebfe_pkg::SEEBFE_WORD;
                        end
                    end
                    seebfe_pkg::SEEBFE_WORD: begin
                        addr_reg[7:0] <= rx_byte;
                        state_reg     <= seebfe_pkg::SEEBFE_WDATA;
                    end
                    seebfe_pkg::SEEBFE_WDATA: begin
                        // Hand each byte over unless protected; a full page wraps in page
                        if (wr_allow) begin
                            wr_hold_reg <= '{addr: addr_reg, data: rx_byte};
                            wr_tgl_reg  <= ~wr_tgl_reg;          // RL5
                        end
                        addr_reg     <= page_next;               // RL2
                    end
                    seebfe_pkg::SEEBFE_RDATA: begin
                        addr_reg <= addr_reg + 9'h001;           // RL4
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    wire ack_slot = bit_cnt_reg == seebfe_pkg::BIT_ACK;
    wire we_ack   = ack_slot && !start_pend &&
        (state_reg == seebfe_pkg::SEEBFE_WORD ||
         state_reg == seebfe_pkg::SEEBFE_WDATA ||
         (state_reg == seebfe_pkg::SEEBFE_RDATA &&
          bit_cnt_reg == seebfe_pkg::BIT_ACK && rw_reg &&
          1'b0));
    // Ack of the select byte only; a flag, since state has moved on and
    // the controller's own ack slot of a read must stay free
    wire sel_ack  = ack_slot && sel_ack_reg;

    // Transmit side: the line changes only on the falling clock edge.
    // Read data bits are taken from the core copy at each fall, MSB first.
    always_ff @(negedge scl_in) begin
        ack_drive_reg <= 1'b0;
        tx_bit_reg    <= 1'b1;
        if (state_reg == seebfe_pkg::SEEBFE_RDATA && !ack_slot) begin
            tx_bit_reg <= rd_byte_l[3'h7 - bit_cnt_reg[2:0]];    // RL10
        end else if ((we_ack || sel_ack) && !rw_reg) begin
            ack_drive_reg <= 1'b1;                               // RL10
        end else if (sel_ack && state_reg == seebfe_pkg::SEEBFE_RDATA) begin
            ack_drive_reg <= 1'b1;
        end
    end

    // Open drain: only pull low or release
    assign sda_out = 1'b0;                                       // RL8
    assign sda_oe  = ack_drive_reg ||
        (state_reg == seebfe_pkg::SEEBFE_RDATA && !tx_bit_reg);  // RL8

    // Busy flag and strap/protect pins into the link domain, two flops
    always_ff @(posedge scl_in) begin
        busy_l1_reg <= write_busy;
        busy_l2_reg <= busy_l1_reg;
        pin_s1_reg  <= {chip_select_strap_high, chip_select_strap_low,
                        write_protect};
        pin_s2_reg  <= pin_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // Core domain: program queue and self-timed write

    logic [2:0]  wr_sync_reg;
    logic [22:0] wtimer_reg;
    logic [22:0] wtimer_next;
    seebfe_pkg::seebfe_wr_s wr_core;
    logic [2:0]  stop_sync_reg;
    logic        pend_reg;
    logic [7:0]  rd_data;

    wire wr_event   = !srst && (wr_sync_reg[2] ^ wr_sync_reg[1]);
    wire stop_event = stop_sync_reg[2] ^ stop_sync_reg[1];
    assign wr_core  = wr_hold_reg;   // Stable long before toggle lands

    // Toggle synchronisers; only stage two onward is looked at. They keep
    // tracking through reset, so a reset never fakes a toggle edge.
    always_ff @(posedge core_clk) begin
        wr_sync_reg   <= {wr_sync_reg[1:0], wr_tgl_reg};
        stop_sync_reg <= {stop_sync_reg[1:0], stop_tgl_reg};
    end

    // Bytes are written as they arrive; the stop starts the 5 ms busy
    // window. Trade-off: array updates early, busy models cycle time.
    assign wtimer_next = (wtimer_reg != 23'h0) ? wtimer_reg - 23'h1 :
        (stop_event && pend_reg) ?
            23'(seebfe_pkg::WRITE_CYCLES) : 23'h0;               // RL3
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wtimer_reg <= 23'h0;
            pend_reg   <= 1'b0;
        end else begin
            wtimer_reg <= wtimer_next;
            pend_reg   <= wr_event || (pend_reg && !stop_event);
        end
    end
    assign write_busy = wtimer_reg != 23'h0;                     // RL3

    seebfe_mem u_mem (                                           // RL1
        .clk   (core_clk),
        .we    (wr_event),
        .waddr (wr_core.addr),
        .wdata (wr_core.data),
        .raddr (addr_reg),
        .rdata (rd_data)
    );
    assign rd_byte_l = rd_data;  // Settles within the clock-low pause before each ack bit
endmodule : seebfe_top

// *** bench/seebfe_asserts.sv ***
// Checker for the EEPROM bus front end, bound to seebfe_top.
// Assumes the serial clock stands high between frames.
`timescale 1ns/1ps
module seebfe_asserts (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic chip_select_strap_low,
    input wire logic chip_select_strap_high,
    input wire logic write_protect,
    input wire logic write_busy
);
    localparam int BUSY_MAX = 200000;
    logic [17:0] busy_cnt_reg;
    logic        oe_low_end_reg = 1'b0;
    // Busy length; 18 bits cannot wrap before the bound trips
    always_ff @(posedge core_clk)
        busy_cnt_reg <= (srst || !write_busy) ? 18'h0 : busy_cnt_reg + 18'h1;
    // Drive level at the end of each low phase
    always_ff @(posedge scl_in) oe_low_end_reg <= sda_oe;
    ////////////////////////////////////////////////////////////////////////
    property p_sda_low; @(posedge core_clk) disable iff (srst) !sda_out;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("data pin driven high");
    property p_oe_fall;
        @(negedge scl_in) disable iff (srst) sda_oe == oe_low_end_reg;
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("data drive changed while clock high");
    property p_oe_span; @(posedge scl_in) disable iff (srst)
        sda_oe [*8] ##1 sda_oe |=> !sda_oe; endproperty
    a_oe_span: assert property (p_oe_span)
        else $error("data line held past one byte and ack");
    property p_oe_idle; @(posedge core_clk) disable iff (srst)
        scl_in [*8] |-> !sda_oe; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data line held on an idle bus");
    property p_busy_hold; @(posedge core_clk) disable iff (srst)
        $rose(write_busy) |=> write_busy [*8]; endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped early");
    property p_busy_max; @(posedge core_clk) disable iff (srst)
        write_busy |-> busy_cnt_reg < BUSY_MAX; endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("write cycle too long");
    property p_busy_idle; @(posedge core_clk) disable iff (srst)
        $rose(write_busy) |-> scl_in && sda_in; endproperty
    a_busy_idle: assert property (p_busy_idle)
        else $error("busy rose with bus active");
    property p_busy_quiet; @(posedge core_clk) disable iff (srst)
        write_busy |-> !sda_oe; endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("answered while programming");
    c_ack: cover property (@(posedge scl_in) sda_oe);
    c_busy: cover property (@(posedge core_clk) $rose(write_busy));
    c_read: cover property (@(posedge scl_in) sda_oe [*2]);
endmodule : seebfe_asserts
bind seebfe_top seebfe_asserts u_chk (
    .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap_low(chip_select_strap_low),
    .chip_select_strap_high(chip_select_strap_high),
    .write_protect(write_protect), .write_busy(write_busy));

// *** bench/seebfe_ctrl_model.sv ***
// Two-wire controller model: serial clock of 6 ns period within frames.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module seebfe_ctrl_model (
    output logic     scl,
    output logic     sda_pull,
    input wire logic sda_line
);
    // Clock held low this long before each ack bit, so the slow core
    // clock can move a written byte or fetch the next read byte
    localparam int ACK_PAUSE = 200;
    // Clock rests high between frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    // Data only pulled low or released, changed while clock is low
    task automatic put_bit(input logic b);
        #1 sda_pull = !b;
        #2 scl = 1'b1;
        #3 scl = 1'b0;
    endtask : put_bit
    task automatic get_bit(output logic b);
        #1 sda_pull = 1'b0;
        #2 scl = 1'b1;
        b = sda_line;
        #3 scl = 1'b0;
    endtask : get_bit
    task automatic start();
        #1 sda_pull = 1'b0;
        #2 scl = 1'b1;
        #3 sda_pull = 1'b1;
        #3 scl = 1'b0;
    endtask : start
    task automatic stop();
        #1 sda_pull = 1'b1;
        #2 scl = 1'b1;
        #3 sda_pull = 1'b0;
    endtask : stop
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        #ACK_PAUSE;
        get_bit(b);
        ack = !b;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        #ACK_PAUSE;
        put_bit(last);
    endtask : recv_byte
endmodule : seebfe_ctrl_model

// *** bench/seebfe_top_test.sv ***
// Self-checking bench for the EEPROM bus front end.
// Assumes a pull-up on the data line; straps and protect set here.
`timescale 1ns/1ps
module seebfe_top_test;
    logic       core_clk = 1'b0;
    logic       srst     = 1'b1;
    logic       wp       = 1'b0;
    logic [1:0] strap    = 2'b10;
    logic       scl, pull, sda_oe, sda_out, busy;
    wire        sda = !(pull || (sda_oe && !sda_out));
    int         err_total = 0;
    int         comparisons = 0;
    int         cycles = 0;
    seebfe_ctrl_model ctrl (.scl(scl), .sda_pull(pull), .sda_line(sda));
    seebfe_top uut (.core_clk(core_clk), .srst(srst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_strap_low(strap[0]), .chip_select_strap_high(strap[1]),
        .write_protect(wp), .write_busy(busy));
    initial forever #12.5 core_clk = !core_clk;
    // Hang guard; the whole run needs a few hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Reset ends a write cycle early; the array itself keeps its data
    task automatic core_reset();
        @(posedge core_clk) srst <= 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
    endtask : core_reset
    task automatic head(input logic [1:0] sel, input logic [8:0] a,
                        output logic ok);
        logic k;
        ctrl.start();
        ctrl.send_byte({seebfe_pkg::SELECT_CODE, sel, a[8], 1'b0}, ok);
        ctrl.send_byte(a[7:0], k);
        ok = ok & k;
    endtask : head
    task automatic probe(input logic [1:0] sel, input logic [7:0] exp);
        logic       ok;
        logic [7:0] d;
        ctrl.start();
        ctrl.send_byte({seebfe_pkg::SELECT_CODE, sel, 2'b01}, ok);
        ctrl.recv_byte(d, 1'b1);
        ctrl.stop();
        check({7'h0, ok}, exp);
    endtask : probe
    task automatic write_run(input logic [8:0] a, input logic [7:0] d0,
                             input int n, input logic chk);
        logic ok;
        logic k;
        head(strap, a, ok);
        check({7'h0, ok}, 8'h01);
        for (int i = 0; i < n; i++) ctrl.send_byte(d0 + 8'(i), k);
        ctrl.stop();
        repeat (10) @(posedge core_clk);
        check({7'h0, busy}, {7'h0, chk});
        if (chk) probe(strap, 8'h00);
        core_reset();
    endtask : write_run
    task automatic read_run(input logic [8:0] a, input logic [7:0] e0,
                            input int n);
        logic       ok;
        logic [7:0] d;
        head(strap, a, ok);
        ctrl.start();
        ctrl.send_byte({seebfe_pkg::SELECT_CODE, strap, a[8], 1'b1}, ok);
        for (int i = 0; i < n; i++) begin
            ctrl.recv_byte(d, i == n - 1);
            check(d, e0 + 8'(i));
        end
        ctrl.stop();
    endtask : read_run
    ////////////////////////////////////////////////////////////////////////
    // Four bytes from 0x1fd: the last one wraps to 0x1f0 in its page
    task automatic t_page();
        write_run(9'h1fd, 8'h5a, 4, 1'b1);
        read_run(9'h1fd, 8'h5a, 3);
        read_run(9'h1f0, 8'h5d, 1);
    endtask : t_page
    task automatic t_protect();
        @(posedge core_clk) wp <= 1'b1;
        write_run(9'h1f0, 8'h11, 1, 1'b0);
        write_run(9'h0f0, 8'h22, 1, 1'b1);
        read_run(9'h1f0, 8'h5d, 1);
        read_run(9'h0f0, 8'h22, 1);
        @(posedge core_clk) wp <= 1'b0;
    endtask : t_protect
    task automatic t_strap();
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk) strap <= 2'(s);
            @(posedge core_clk);
            probe(2'(s) ^ 2'b01, 8'h00);
            probe(2'(s), 8'h01);
        end
    endtask : t_strap
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_page();
        t_protect();
        t_strap();
        wrap_up();
    end
endmodule : seebfe_top_test
